// >>> src/pbs_fifo.sv
// flip-flop fifo with valid/ready on both sides
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } pbs_fifo_t;

  pbs_fifo_t s_ff;
  pbs_fifo_t nxt_s;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready = (s_ff.cnt != CW'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data = s_ff.mem[s_ff.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer wrap is explicit so depth need not be a power of two
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = (s_ff.wr == PW'(DEPTH - 1)) ? '0 : s_ff.wr + PW'(1);
    end
    if (pop) begin
      nxt_s.rd = (s_ff.rd == PW'(DEPTH - 1)) ? '0 : s_ff.rd + PW'(1);
    end
    nxt_s.cnt = s_ff.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

// >>> src/pbs_pkg.sv
// constants shared by the burst sram access block and its write queue
package pbs_pkg;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int LANE_DQ_W = 8;
  localparam int WORD_W = DQ_W + LANES;
  localparam int ADDR_W = 4;
  localparam int MEM_DEPTH = 16;
  localparam int BURST_W = 2;
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_W = ADDR_W + LANES + WORD_W;
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic [1:0] SYNC_RST_LOW = 2'h0;
  localparam logic [1:0] SYNC_RST_HIGH = 2'h3;
  localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;
endpackage

// >>> src/pbs_sram.sv
// pipelined zero-wait burst sram access logic with byte-lane writes

module pbs_sram (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_qualify_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic advance_load,
  input wire logic write_enable_n,
  input wire logic [pbs_pkg::LANES-1:0] byte_lane_select_n,
  input wire logic [pbs_pkg::ADDR_W-1:0] addr,
  input wire logic output_enable_n,
  input wire logic burst_order,
  input wire logic sleep_request,
  input wire logic [pbs_pkg::DQ_W-1:0] dq_in,
  output logic [pbs_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [pbs_pkg::LANES-1:0] parity_lines_in,
  output logic [pbs_pkg::LANES-1:0] parity_lines_out,
  output logic parity_lines_oe,
  output logic wr_queue_ready,
  output logic sleeping
);
  localparam int AW = pbs_pkg::ADDR_W;
  localparam int WW = pbs_pkg::WORD_W;
  localparam int LN = pbs_pkg::LANES;
  localparam int BW = pbs_pkg::BURST_W;
  localparam int DW = pbs_pkg::LANE_DQ_W;
  localparam int LW = pbs_pkg::LANE_DQ_W + 1;

  typedef struct packed {
    logic [1:0] slp;
    logic [1:0] oe_n;
    logic [1:0] mode;
    logic active;
    logic burst_wr;
    logic [AW-1:0] base;
    logic [BW-1:0] beat;
    logic a_vld;
    logic a_wr;
    logic [AW-1:0] a_addr;
    logic [LN-1:0] a_lanes;
    logic b_vld;
    logic b_wr;
    logic [AW-1:0] b_addr;
    logic [LN-1:0] b_lanes;
    logic drive;
    logic [WW-1:0] dout;
    logic [pbs_pkg::MEM_DEPTH-1:0][WW-1:0] mem;
  } pbs_state_t;

  pbs_state_t s_ff;
  pbs_state_t nxt_s;

  logic selected;
  logic run;
  logic q_in_valid;
  logic q_in_ready;
  logic [pbs_pkg::QUEUE_W-1:0] q_in_data;
  logic q_out_valid;
  logic q_out_ready;
  logic [pbs_pkg::QUEUE_W-1:0] q_out_data;
  logic [AW-1:0] q_addr;
  logic [LN-1:0] q_lanes;
  logic [WW-1:0] q_word;
  logic [WW-1:0] in_word;
  logic [WW-1:0] rd_word;
  logic [LN-1:0] lane_mask;
  logic [WW-1:0] bit_mask;
  logic [WW-1:0] fwd_mask;

  // a word is laid out lane by lane: parity bit above its eight data bits
  function automatic logic [WW-1:0] pack_word(
    input logic [pbs_pkg::DQ_W-1:0] d,
    input logic [LN-1:0] p
  );
    logic [WW-1:0] w;
    w = '0;
    for (int i = 0; i < LN; i++) begin
      w[i*LW +: LW] = {p[i], d[i*DW +: DW]};
    end
    return w;
  endfunction

  // next beat address within the aligned group of four
  function automatic logic [AW-1:0] beat_addr(
    input logic [AW-1:0] base,
    input logic [BW-1:0] beat,
    input logic mode
  );
    logic [AW-1:0] a;
    a = base;
    if (mode == pbs_pkg::MODE_LINEAR) begin
      a[BW-1:0] = base[BW-1:0] + beat;
    end else begin
      a[BW-1:0] = base[BW-1:0] ^ beat;
    end
    return a;
  endfunction

  // per-lane bit mask, one lane per loop pass
  assign lane_mask = q_lanes;
  for (genvar g = 0; g < LN; g++) begin : g_mask
    assign bit_mask[g*LW +: LW] = {LW{lane_mask[g]}};
    assign fwd_mask[g*LW +: LW] = {LW{s_ff.b_lanes[g]}};
  end

  assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign sleeping = s_ff.slp[1];
  assign run = !sleeping && !clock_qualify_n;
  assign in_word = pack_word(dq_in, parity_lines_in);
  assign {q_addr, q_lanes, q_word} = q_out_data;

  // write data enters the queue at the second edge after the command
  assign q_in_valid = run && s_ff.b_vld && s_ff.b_wr
    && (s_ff.b_lanes != '0);
  assign q_in_data = {s_ff.b_addr, s_ff.b_lanes, in_word};
  assign wr_queue_ready = q_in_ready;
  // the array is not written while asleep, so stored data survives
  assign q_out_ready = !sleeping;

  // read bypass: a queued write to the same word is not yet in the array
  always_comb begin
    rd_word = s_ff.mem[s_ff.a_addr];
    if (q_out_valid && q_addr == s_ff.a_addr) begin
      rd_word = (rd_word & ~bit_mask) | (q_word & bit_mask);
    end
    // a read right behind a write to the same word takes the bus data
    // being captured now, so back-to-back commands stay coherent
    if (s_ff.b_vld && s_ff.b_wr && s_ff.b_addr == s_ff.a_addr) begin
      rd_word = (rd_word & ~fwd_mask) | (in_word & fwd_mask);
    end
  end

  pbs_fifo #(
    .WIDTH(pbs_pkg::QUEUE_W),
    .DEPTH(pbs_pkg::QUEUE_DEPTH)
  ) u_wr_queue (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in_data),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out_data)
  );

  // pipeline: command edge -> stage a -> stage b / output register
  always_comb begin
    nxt_s = s_ff;
    // async pins pass two flops; the strap is static so delay is harmless
    nxt_s.slp = {s_ff.slp[0], sleep_request};
    nxt_s.oe_n = {s_ff.oe_n[0], output_enable_n};
    nxt_s.mode = {s_ff.mode[0], burst_order};
    // drain one queued write per cycle, selected lanes only
    if (q_out_valid && q_out_ready) begin
      nxt_s.mem[q_addr] = (s_ff.mem[q_addr] & ~bit_mask)
        | (q_word & bit_mask);
    end
    if (sleeping) begin
      // stages a and b and the output drive are abandoned; queued writes are kept
      nxt_s.active = 1'b0;
      nxt_s.a_vld = 1'b0;
      nxt_s.b_vld = 1'b0;
      nxt_s.drive = 1'b0;
    end else if (run) begin
      // stage a moves on to stage b every qualified edge
      nxt_s.b_vld = s_ff.a_vld;
      nxt_s.b_wr = s_ff.a_wr;
      nxt_s.b_addr = s_ff.a_addr;
      nxt_s.b_lanes = s_ff.a_lanes;
      // output register: read data one edge after the command
      nxt_s.drive = s_ff.a_vld && !s_ff.a_wr;
      nxt_s.dout = rd_word;
      // a new command is decoded on every qualified edge with advance_load low
      if (!advance_load) begin
        if (selected) begin
          nxt_s.active = 1'b1;
          nxt_s.burst_wr = !write_enable_n;
          nxt_s.base = addr;
          nxt_s.beat = pbs_pkg::BEAT_FIRST;
          nxt_s.a_vld = 1'b1;
          nxt_s.a_wr = !write_enable_n;
          nxt_s.a_addr = addr;
          nxt_s.a_lanes = ~byte_lane_select_n;
        end else begin
          // deselect: next output edge releases the bus
          nxt_s.active = 1'b0;
          nxt_s.a_vld = 1'b0;
        end
      end else if (s_ff.active) begin
        // advance: chip selects and write strobe are not looked at
        nxt_s.beat = s_ff.beat + pbs_pkg::BEAT_STEP;
        nxt_s.a_vld = 1'b1;
        nxt_s.a_wr = s_ff.burst_wr;
        nxt_s.a_addr = beat_addr(s_ff.base,
          s_ff.beat + pbs_pkg::BEAT_STEP, s_ff.mode[1]);
        nxt_s.a_lanes = ~byte_lane_select_n;
      end else begin
        // advance while deselected just continues the deselect
        nxt_s.a_vld = 1'b0;
      end
    end
  end

  // synchronous reset leaves the device deselected with the bus released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.oe_n <= pbs_pkg::SYNC_RST_HIGH;
      s_ff.mode <= pbs_pkg::SYNC_RST_HIGH;
      s_ff.slp <= pbs_pkg::SYNC_RST_LOW;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // drive only for read data, gated by the enable and by sleep
  always_comb begin
    for (int i = 0; i < LN; i++) begin
      dq_out[i*DW +: DW] = s_ff.dout[i*LW +: DW];
      parity_lines_out[i] = s_ff.dout[i*LW + DW];
    end
  end

  // write cycles never set drive, so the bus is free for write data
  assign dq_oe = s_ff.drive && !s_ff.oe_n[1] && !sleeping;
  assign parity_lines_oe = dq_oe;
endmodule

// >>> testbench/pbs_host_model.sv
// host-side model that drives write data in the data phase
module pbs_host_model (
  input wire logic clk,
  input wire logic clock_qualify_n,
  input wire logic dq_oe,
  input wire logic wr_beat,
  input wire logic [35:0] wr_word,
  output logic [31:0] dq_in,
  output logic [3:0] parity_lines_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] beat_q = 2'h0;
  logic [35:0] word_q [2];
  // data trails its command by two taken edges; stalls hold it back
  always @(posedge clk) begin
    if (!clock_qualify_n) begin
      beat_q <= {beat_q[0], wr_beat};
      word_q <= '{wr_word, word_q[0]};
    end
  end
  // never fight the device; outside a data phase the lines keep toggling
  always @(negedge clk) begin
    if (beat_q[1] && !dq_oe) begin
      {parity_lines_in, dq_in} <= word_q[1];
    end else begin
      {parity_lines_in, dq_in} <= ~{parity_lines_in, dq_in};
    end
  end
  initial {parity_lines_in, dq_in} = 36'h0;
endmodule

// >>> testbench/pbs_sram_properties.sv
// pin-level assertions for the burst sram access block
module pbs_sram_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_qualify_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic advance_load,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [pbs_pkg::DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic parity_lines_oe,
  input wire logic sleeping
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel;
  logic load;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a taken load edge; selects only count when loading
  assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign load = !clock_qualify_n && !sleeping && !advance_load;
  // the enable passes two flops, so driving means it was low two edges back
  par_oe_a: assert property (
    dq_oe |-> parity_lines_oe && !$past(output_enable_n, 2))
    else $error("lines driven without enable");
  wr_release_a: assert property (
    load && sel && !write_enable_n ##1 !clock_qualify_n |=> !dq_oe)
    else $error("bus kept after write");
  desel_release_a: assert property (
    load && !sel ##1 !clock_qualify_n |=> !dq_oe)
    else $error("bus kept after deselect");
  // enable passes two flops, so it must be low for a while first
  read_drive_a: assert property (
    (!output_enable_n && !sleep_request)[*3] ##0 load && sel &&
    write_enable_n ##1 !clock_qualify_n |=> dq_oe)
    else $error("read data not driven");
  stall_hold_a: assert property (
    clock_qualify_n && !sleep_request && !sleeping |=> $stable(dq_out))
    else $error("read data moved in stall");
  sleep_in_a: assert property (
    $rose(sleep_request) && !sleeping ##1 sleep_request |->
    !sleeping ##1 sleeping) else $error("sleep entry time");
  sleep_out_a: assert property (
    $fell(sleep_request) && sleeping ##1 !sleep_request |->
    sleeping ##1 !sleeping) else $error("sleep exit time");
  // also covers the first cycle after waking: the pipeline must be empty
  sleep_quiet_a: assert property (sleeping |=> !dq_oe)
    else $error("bus driven asleep");
endmodule
bind pbs_sram pbs_sram_properties chk_u (.*);

// >>> testbench/tb_pbs_sram.sv
// self-checking bench for the burst sram access block
module tb_pbs_sram;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, clock_qualify_n, chip_select_1_n, chip_select_2;
  logic chip_select_3_n, advance_load, write_enable_n, output_enable_n;
  logic burst_order, sleep_request, dq_oe, parity_lines_oe, sleeping;
  logic wr_queue_ready, wr_beat;
  logic [3:0] byte_lane_select_n, addr, parity_lines_in, parity_lines_out;
  logic [31:0] dq_in, dq_out;
  logic [35:0] wr_word;
  int miscompares = 0;
  int checks_done = 0;
  pbs_sram dut_u (.*);
  pbs_host_model host_u (.*);
  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one command: pins move at the fall, the device takes them at the rise
  task automatic cyc(input logic s, adv, wn, wb, input logic [3:0] ln, a,
      input logic [35:0] wd);
    @(negedge clk);
    {chip_select_1_n, chip_select_2, chip_select_3_n} = {!s, s, !s};
    {advance_load, write_enable_n, wr_beat, wr_word} = {adv, wn, wb, wd};
    {byte_lane_select_n, addr} = {ln, a};
    @(posedge clk);
    #1;
  endtask
  function automatic logic [35:0] w(input int k);
    return {4'(k + 1), 32'hC0DE_0000 | 32'(k)};
  endfunction
  task automatic idle(input int n);
    repeat (n) cyc(0, 0, 1, 0, 4'hF, 4'h0, 36'h0);
  endtask
  // linear burst write from 9 against flipped selects, then read back
  task automatic t_linear();
    cyc(1, 0, 0, 1, 4'h0, 4'h9, w(0));
    for (int k = 1; k < 4; k++) begin
      cyc(0, 1, 1, 1, 4'h0, 4'h0, w(k));
    end
    for (int k = 0; k < 5; k++) begin
      if (k < 4) cyc(1, 0, 1, 0, 4'hF, 4'(8 + (k + 1) % 4), 36'h0);
      else idle(1);
      if (k > 0) chk({parity_lines_out, dq_out}, w(k - 1));
    end
    idle(1);
    chk(36'(dq_oe), 36'h0);
  endtask
  // interleaved read burst from 9; the fourth advance wraps to the start
  task automatic t_inter();
    int order[5] = '{0, 3, 2, 1, 0};
    @(negedge clk) burst_order = 1'b1; // moved only while idle
    idle(3);
    for (int k = 0; k < 6; k++) begin
      if (k == 0) cyc(1, 0, 1, 0, 4'hF, 4'h9, 36'h0);
      else if (k < 5) cyc(0, 1, 0, 0, 4'h0, 4'h0, 36'h0);
      else idle(1);
      if (k > 0) chk({parity_lines_out, dq_out}, w(order[k - 1]));
    end
  endtask
  // lane write stalled in its data phase, then a write with no lanes
  task automatic t_lanes();
    cyc(1, 0, 0, 1, 4'hA, 4'h3, 36'hF_FFFF_FFFF);
    idle(1);
    @(negedge clk) clock_qualify_n = 1'b1;
    repeat (2) @(negedge clk);
    clock_qualify_n = 1'b0;
    idle(2);
    cyc(1, 0, 0, 1, 4'hF, 4'h3, 36'h0);
    idle(2);
    cyc(1, 0, 1, 0, 4'hF, 4'h3, 36'h0);
    idle(1);
    chk({parity_lines_out, dq_out}, {4'h5, 32'h00FF_00FF});
  endtask
  // sleep keeps the array and ignores a write issued while asleep
  task automatic t_sleep();
    @(negedge clk) sleep_request = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(36'(sleeping), 36'h1);
    cyc(1, 0, 0, 1, 4'h0, 4'h3, 36'h0);
    idle(2);
    chk(36'(dq_oe), 36'h0);
    @(negedge clk) sleep_request = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(36'(sleeping), 36'h0);
    chk(36'(wr_queue_ready), 36'h1);
    idle(2);
    cyc(1, 0, 1, 0, 4'hF, 4'h3, 36'h0);
    idle(1);
    chk({parity_lines_out, dq_out}, {4'h5, 32'h00FF_00FF});
  endtask
  // read right behind a write to one word, then the same read, enable off
  task automatic t_fwd();
    cyc(1, 0, 0, 1, 4'h3, 4'h5, 36'hA_1234_5678);
    cyc(1, 0, 1, 0, 4'hF, 4'h5, 36'h0);
    idle(1);
    chk({parity_lines_out, dq_out}, {4'h8, 32'h1234_0000});
    chk(36'(parity_lines_oe), 36'h1);
    @(negedge clk) output_enable_n = 1'b1;
    idle(1);
    cyc(1, 0, 1, 0, 4'hF, 4'h5, 36'h0);
    idle(1);
    chk(36'(dq_oe), 36'h0);
    chk({parity_lines_out, dq_out}, {4'h8, 32'h1234_0000});
    @(negedge clk) output_enable_n = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // four reset cycles, then the scenarios
  initial begin
    {rst_n, clock_qualify_n, output_enable_n, burst_order} = 4'h0;
    {sleep_request, wr_beat, wr_word} = 38'h0;
    {chip_select_1_n, chip_select_2, chip_select_3_n} = 3'h5;
    {advance_load, write_enable_n, byte_lane_select_n, addr} = 10'h1F0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    idle(3);
    t_linear();
    t_inter();
    t_fwd();
    t_lanes();
    t_sleep();
    print_verdict();
  end
  // the scenarios need about 60 cycles; this allows far more
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule
